// ### tod_pkg.sv
// shared constants and types for the time-of-day and interval timer block
package tod_pkg;
    // ========================================================================
    // time base
    localparam int CLK_PERIOD_NS = 50;
    localparam int TOD_TICK_NS   = 1000;
    localparam int US_CYCLES     = (TOD_TICK_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int IT_RES_US     = 3330;       // 3.33 ms in microseconds
    // ========================================================================
    // time-of-day counter
    localparam int TOD_WIDTH       = 52;
    localparam int TOD_STORE_SHIFT = 12;       // unit bit of stored value
    localparam logic [51:0] TOD_RESET = 52'h0;
    // ========================================================================
    // interval timer in fixed storage
    localparam logic [23:0] IT_ADDR = 24'h000050;   // byte location 80
    // one resolution unit; 2**24 units make the 15.5 hour cycle
    localparam logic [31:0] IT_UNIT = 32'h00000100;
    localparam int ADDR_WIDTH = 24;
    localparam int DATA_WIDTH = 64;
    // ========================================================================
    // storage port
    typedef struct packed {
        logic        req;
        logic        we;
        logic        lock;
        logic [23:0] addr;
        logic [63:0] wdata;
    } stor_req_t;
endpackage : tod_pkg

// ============================================================================
// enabled divider: one-cycle pulse every DIV enabled cycles
`timescale 1ns/100ps
module tick_div #(
    parameter int DIV = 20
) (
    input  wire logic clk,                    // clock
    input  wire logic rst_b,                  // sync reset, active low
    input  wire logic en,                     // count enable
    output logic      tick                    // one-cycle pulse
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    logic [CW-1:0] cnt;

    initial begin
        if (DIV < 1) $error("tick_div: DIV must be at least 1");
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (en) begin
                if (cnt == CW'(DIV - 1)) begin
                    cnt  <= '0;
                    tick <= 1'b1;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end
endmodule // tick_div

// ### tod_timer.sv
// time-of-day counter and interval timer updater
//
// Behaviour
// - time-of-day is a 52-bit binary counter that wraps at its maximum.
// - counter increments by one on every microsecond tick, except one that falls in the cycle a set is loaded.
// - set loads only in supervisor state with security switch at enable.
// - store command writes the counter into the given doubleword.
// - counter runs even while stopped; only power removal halts it.
// - interval timer lives at location 80, updated every 3.33 ms.
// - interval timer count spans 15.5 hours before wrapping.
// - interval timer updates suspended while the system is stopped.
// - updates may be skipped when storage is too busy to take them.
`timescale 1ns/100ps
module tod_timer
    import tod_pkg::*;
#(
    parameter int IT_TICKS = IT_RES_US        // microseconds per update
) (
    input  wire logic                  MCLK,        // 20 MHz clock
    input  wire logic                  RST_B,       // sync reset, low
    input  wire logic                  SUPERVISOR,  // cpu in supervisor state
    input  wire logic                  SEC_ENABLE,  // console switch, async
    input  wire logic                  STOPPED,     // system stopped state
    input  wire logic                  SET_REQ,     // set command pulse
    input  wire logic [TOD_WIDTH-1:0]  SET_VALUE,   // value to load
    input  wire logic                  STORE_REQ,   // store command pulse
    input  wire logic [ADDR_WIDTH-1:0] STORE_ADDR,  // doubleword address
    input  wire logic                  STOR_ACK,    // storage done, 1 cycle
    input  wire logic [DATA_WIDTH-1:0] STOR_RDATA,  // read data with ack
    output stor_req_t                  STOR,        // storage request
    output logic [TOD_WIDTH-1:0]       TOD_VALUE,   // counter value
    output logic                       SET_DONE,    // set accepted pulse
    output logic                       SET_REJECT,  // set refused pulse
    output logic                       STORE_DONE,  // store written pulse
    output logic                       STORE_BUSY,  // store in progress
    output logic                       IT_SKIPPED   // update dropped pulse
);
    initial begin
        if (IT_TICKS < 1) $error("tod_timer: IT_TICKS must be positive");
    end

    // ========================================================================
    // console switch synchroniser
    logic sec_meta;
    logic sec_sync;
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            sec_meta <= 1'b0;
            sec_sync <= 1'b0;
        end else begin
            sec_meta <= SEC_ENABLE;
            sec_sync <= sec_meta;
        end
    end

    // ========================================================================
    // time bases
    logic us_tick;
    logic it_tick;

    tick_div #(.DIV(US_CYCLES)) u_us_div (
        .clk   (MCLK),
        .rst_b (RST_B),
        .en    (1'b1),
        .tick  (us_tick)
    );

    // the divider holds its phase while stopped rather than restarting
    tick_div #(.DIV(IT_TICKS)) u_it_div (
        .clk   (MCLK),
        .rst_b (RST_B),
        .en    (us_tick && !STOPPED),
        .tick  (it_tick)
    );

    // ========================================================================
    // time-of-day counter
    logic set_ok;
    assign set_ok = SET_REQ && SUPERVISOR && sec_sync;

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            TOD_VALUE <= TOD_RESET;
        end else if (set_ok) begin
            TOD_VALUE <= SET_VALUE;
        end else if (us_tick) begin
            // no stop term: only power removal halts it
            TOD_VALUE <= TOD_VALUE + 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            SET_DONE   <= 1'b0;
            SET_REJECT <= 1'b0;
        end else begin
            SET_DONE   <= set_ok;
            SET_REJECT <= SET_REQ && !set_ok;
        end
    end

    // ========================================================================
    // storage sequencer
    typedef enum logic [1:0] {ST_IDLE, ST_STORE, ST_IT_RD, ST_IT_WR} st_t;
    st_t state;

    logic                  store_pend;
    logic [ADDR_WIDTH-1:0] store_addr;
    logic [TOD_WIDTH-1:0]  store_val;
    logic                  it_pend;
    logic                  it_start;

    // a stopped system leaves a due update waiting rather than starting it
    assign it_start = (state == ST_IDLE) && !store_pend && it_pend
                      && !STOPPED;

    // store command is latched; a second one while busy is ignored
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            store_pend <= 1'b0;
            store_addr <= '0;
            store_val  <= TOD_RESET;
        end else if (STORE_REQ && !store_pend) begin
            store_pend <= 1'b1;
            store_addr <= STORE_ADDR;
            store_val  <= TOD_VALUE;
        end else if (state == ST_STORE && STOR_ACK) begin
            store_pend <= 1'b0;
        end
    end

    // an update still waiting when the next one falls due is dropped
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            it_pend    <= 1'b0;
            IT_SKIPPED <= 1'b0;
        end else begin
            // an update starting now frees the slot for the new one
            IT_SKIPPED <= it_tick && it_pend && !it_start;
            if (it_tick) begin
                it_pend <= 1'b1;
            end else if (it_start) begin
                it_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            state <= ST_IDLE;
            STOR  <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (store_pend) begin
                        state      <= ST_STORE;
                        STOR.req   <= 1'b1;
                        STOR.we    <= 1'b1;
                        STOR.lock  <= 1'b0;
                        STOR.addr  <= store_addr;
                        STOR.wdata <= {store_val,
                                       TOD_STORE_SHIFT'(0)};
                    end else if (it_start) begin
                        state      <= ST_IT_RD;
                        STOR.req   <= 1'b1;
                        STOR.we    <= 1'b0;
                        STOR.lock  <= 1'b1;
                        STOR.addr  <= IT_ADDR;
                        STOR.wdata <= '0;
                    end
                end
                ST_STORE: begin
                    if (STOR_ACK) begin
                        state    <= ST_IDLE;
                        STOR.req <= 1'b0;
                        STOR.we  <= 1'b0;
                    end
                end
                ST_IT_RD: begin
                    if (STOR_ACK) begin
                        // word 80 is the high half; wraps over 2**24 units
                        state      <= ST_IT_WR;
                        STOR.we    <= 1'b1;
                        STOR.wdata <= {STOR_RDATA[63:32] - IT_UNIT,
                                       STOR_RDATA[31:0]};
                    end
                end
                ST_IT_WR: begin
                    if (STOR_ACK) begin
                        state     <= ST_IDLE;
                        STOR.req  <= 1'b0;
                        STOR.we   <= 1'b0;
                        STOR.lock <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    STOR  <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            STORE_DONE <= 1'b0;
            STORE_BUSY <= 1'b0;
        end else begin
            STORE_DONE <= (state == ST_STORE) && STOR_ACK;
            // busy mirrors the pending flag, so the done cycle reads idle
            // and a new command may be taken in that very cycle
            STORE_BUSY <= (STORE_REQ && !store_pend)
                          || (store_pend
                              && !(state == ST_STORE && STOR_ACK));
        end
    end
endmodule // tod_timer

// ### tod_timer_assertions.sv
// assertion checker for the time-of-day and interval timer block
`timescale 1ns/100ps
// ============================================================
module tod_timer_assertions
    import tod_pkg::*;
(
    input wire logic        MCLK,        // clock
    input wire logic        RST_B,       // reset, low
    input wire logic        SUPERVISOR,  // supervisor
    input wire logic        STOPPED,     // stopped
    input wire logic        SET_REQ,     // set pulse
    input wire logic [51:0] SET_VALUE,   // set value
    input wire logic        STORE_REQ,   // store pulse
    input wire logic [23:0] STORE_ADDR,  // store address
    input wire logic        STOR_ACK,    // storage ack
    input wire logic [63:0] STOR_RDATA,  // read data
    input wire stor_req_t   STOR,        // storage request
    input wire logic [51:0] TOD_VALUE,   // counter
    input wire logic        SET_DONE,    // set taken
    input wire logic        SET_REJECT,  // set refused
    input wire logic        STORE_DONE,  // store written
    input wire logic        STORE_BUSY   // store pending
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    logic [51:0] cap;
    logic [23:0] cap_addr;
    logic [63:0] rd;
    // mirror of what a taken store must write
    always_ff @(posedge MCLK) begin
        if (STORE_REQ && !STORE_BUSY) begin
            cap      <= TOD_VALUE;
            cap_addr <= STORE_ADDR;
        end
    end
    always_ff @(posedge MCLK) begin
        rd <= STOR_RDATA;
    end
    tod_step_a: assert property (
        $changed(TOD_VALUE) |-> SET_DONE
        || TOD_VALUE == $past(TOD_VALUE) + 52'h1) else $error("tod jump");
    tod_live_a: assert property (
        1'b1 |-> ##[1:21] $changed(TOD_VALUE)) else $error("tod stalled");
    set_ok_a: assert property (
        SET_DONE |-> $past(SET_REQ) && $past(SUPERVISOR)
        && TOD_VALUE == $past(SET_VALUE)) else $error("bad set");
    set_nosup_a: assert property (
        SET_REQ && !SUPERVISOR |=> SET_REJECT && !SET_DONE)
        else $error("set not refused");
    store_word_a: assert property (
        STOR.req && !STOR.lock |-> STOR.we && STOR.addr == cap_addr
        && STOR.wdata == {cap, 12'h000}) else $error("bad store");
    store_end_a: assert property (
        STORE_BUSY && STOR.req && STOR_ACK && !STOR.lock
        |=> STORE_DONE && !STORE_BUSY && !STOR.req) else $error("store end");
    it_addr_a: assert property (
        STOR.lock |-> STOR.addr == IT_ADDR) else $error("timer addr");
    it_dec_a: assert property (
        STOR.lock && !STOR.we && STOR_ACK |=> STOR.lock && STOR.we
        && STOR.wdata == {rd[63:32] - IT_UNIT, rd[31:0]})
        else $error("timer write");
    it_stop_a: assert property (
        STOPPED [*2] |-> !$rose(STOR.lock)) else $error("update stopped");
    set_c: cover property (SET_DONE);
    rej_c: cover property (SET_REJECT);
    store_c: cover property (STORE_DONE);
endmodule // tod_timer_assertions

bind tod_timer tod_timer_assertions u_chk (.MCLK(MCLK), .RST_B(RST_B),
    .SUPERVISOR(SUPERVISOR), .STOPPED(STOPPED), .SET_REQ(SET_REQ),
    .SET_VALUE(SET_VALUE), .STORE_REQ(STORE_REQ),
    .STORE_ADDR(STORE_ADDR), .STOR_ACK(STOR_ACK),
    .STOR_RDATA(STOR_RDATA), .STOR(STOR), .TOD_VALUE(TOD_VALUE),
    .SET_DONE(SET_DONE), .SET_REJECT(SET_REJECT),
    .STORE_DONE(STORE_DONE), .STORE_BUSY(STORE_BUSY));

// ### tod_timer_test.sv
// self-checking bench for the time-of-day and interval timer block
`timescale 1ns/100ps
module tod_timer_test
    import tod_pkg::*;
;
    // ========================================================
    logic        MCLK = 0, RST_B = 0, SUPERVISOR = 1, SEC_ENABLE = 1;
    logic        STOPPED = 0, SET_REQ = 0, STORE_REQ = 0, STOR_ACK = 0;
    logic [51:0] SET_VALUE = 52'h0, TOD_VALUE, sv;
    logic [23:0] STORE_ADDR = 24'h0, sa;
    logic [63:0] STOR_RDATA = 64'h0;
    logic [31:0] itw = 32'h00000080;
    stor_req_t   STOR;
    logic        SET_DONE, SET_REJECT, STORE_DONE, STORE_BUSY, IT_SKIPPED;
    logic        hold = 0;
    int failures = 0, checks_done = 0, ups = 0, skips = 0, stores = 0;
    always #25 MCLK = ~MCLK;
    tod_timer #(.IT_TICKS(3)) dut (.MCLK(MCLK), .RST_B(RST_B),
        .SUPERVISOR(SUPERVISOR), .SEC_ENABLE(SEC_ENABLE),
        .STOPPED(STOPPED), .SET_REQ(SET_REQ), .SET_VALUE(SET_VALUE),
        .STORE_REQ(STORE_REQ), .STORE_ADDR(STORE_ADDR),
        .STOR_ACK(STOR_ACK), .STOR_RDATA(STOR_RDATA), .STOR(STOR),
        .TOD_VALUE(TOD_VALUE), .SET_DONE(SET_DONE),
        .SET_REJECT(SET_REJECT), .STORE_DONE(STORE_DONE),
        .STORE_BUSY(STORE_BUSY), .IT_SKIPPED(IT_SKIPPED));
    // storage: ack a cycle after the request unless hold is set, data scrambled otherwise
    always @(negedge MCLK) begin
        STOR_ACK   <= STOR.req && !STOR_ACK && !hold;
        STOR_RDATA <= (STOR.req && !STOR_ACK) ? {itw, 32'h00005a5a}
                                              : ~{itw, 32'h00005a5a};
    end
    always @(posedge MCLK) begin
        if (STOR_ACK && STOR.we && STOR.lock) begin
            itw <= STOR.wdata[63:32];
            ups <= ups + 1;
        end
        if (STOR_ACK && STOR.we && !STOR.lock) begin
            sv     <= STOR.wdata[63:12];
            sa     <= STOR.addr;
            stores <= stores + 1;
        end
        if (IT_SKIPPED === 1'b1)
            skips <= skips + 1;
    end
    function automatic bit ck(input bit miss);
        checks_done++;
        return miss;
    endfunction
    task automatic bad(input string m);
        failures++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge MCLK);
    endtask
    task automatic set(input logic [51:0] v);
        SET_VALUE = v;
        SET_REQ = 1;
        cyc(1);
        SET_REQ = 0;
    endtask
    task automatic t_itimer;
        logic [31:0] w0;
        int u0;
        w0 = itw;
        u0 = ups;
        cyc(300);
        if (ck(ups - u0 < 4 || ups - u0 > 6)) bad("update rate");
        if (ck(itw !== w0 - 32'(ups - u0) * IT_UNIT)) bad("timer");
        $display("t_itimer done");
    endtask
    task automatic t_count;
        logic [51:0] t0;
        int u0;
        STOPPED = 1;
        cyc(6);
        t0 = TOD_VALUE;
        u0 = ups;
        cyc(200);
        if (ck(TOD_VALUE !== t0 + 52'ha)) bad("tod rate");
        if (ck(ups != u0)) bad("update while stopped");
        STOPPED = 0;
        cyc(130);
        if (ck(ups == u0)) bad("no resume");
        $display("t_count done");
    endtask
    task automatic t_set;
        set(52'hffffffffffffe);
        if (ck(SET_DONE !== 1'b1)) bad("set");
        cyc(40);
        if (ck(TOD_VALUE !== 52'h0)) bad("wrap");
        for (int i = 0; i < 2; i++) begin
            SUPERVISOR = i[0];
            SEC_ENABLE = !i[0];
            cyc(3);
            set(52'h0000000000123);
            if (ck(SET_REJECT !== 1'b1 || TOD_VALUE === 52'h123))
                bad("ref");
        end
        SUPERVISOR = 1;
        SEC_ENABLE = 1;
        $display("t_set done");
    endtask
    task automatic t_store;
        logic [51:0] exp;
        hold = 1;
        STORE_ADDR = 24'h000100;
        exp = TOD_VALUE;
        STORE_REQ = 1;
        cyc(1);
        STORE_REQ = 0;
        cyc(2);
        if (ck(STORE_BUSY !== 1'b1)) bad("not busy");
        STORE_ADDR = 24'h000200;
        STORE_REQ = 1;
        cyc(1);
        STORE_REQ = 0;
        cyc(200);
        hold = 0;
        for (int n = 0; n < 50 && STORE_DONE !== 1'b1; n++)
            cyc(1);
        if (ck(STORE_DONE !== 1'b1)) begin
            bad("store hang");
            complete_run();
        end
        if (ck(sv !== exp || sa !== 24'h000100)) bad("stored");
        if (ck(STORE_BUSY !== 1'b0)) bad("still busy");
        if (ck(skips == 0)) bad("no skip");
        cyc(30);
        if (ck(stores != 1)) bad("busy store");
        $display("t_store done");
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        cyc(2);
        RST_B = 1;
        t_itimer();
        t_count();
        t_set();
        t_store();
        complete_run();
    end
endmodule // tod_timer_test
